// >>> common/i2ctg_pkg.sv
/*
 i2ctg_pkg: constants for the i2c protocol trigger.
 assumes a single 20 MHz clock domain and a word-aligned register port.
*/
package i2ctg_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR_LO = 8'h04;
  localparam logic [7:0] OFF_ADDR_HI = 8'h08;
  localparam logic [7:0] OFF_PAT_LO = 8'h0C;
  localparam logic [7:0] OFF_PAT_HI = 8'h10;
  localparam logic [7:0] OFF_PAT_LEN = 8'h14;
  localparam logic [7:0] OFF_OFFSET = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  localparam logic [7:0] OFF_MASK = 8'h20;
  localparam logic [7:0] OFF_STATE = 8'h24;
  // control field positions
  localparam int unsigned CTL_TYPE = 0;
  localparam int unsigned CTL_ACC = 3;
  localparam int unsigned CTL_AOP = 5;
  localparam int unsigned CTL_ADDRESS_NOACK_DETECT = 8;
  localparam int unsigned CTL_ALEN = 9;
  localparam int unsigned CTL_DOP = 10;
  localparam int unsigned CTL_READ_END_NOACK_DETECT = 13;
  localparam int unsigned CTL_WRITE_DATA_NOACK_DETECT = 14;
  localparam int unsigned CTL_W = 15;
  localparam logic [14:0] CTRL_RST = 15'h6100;
  localparam logic [3:0] PAT_LEN_RST = 4'h1;
  localparam logic [12:0] OFFSET_RST = 13'h0001;
  // trigger types
  localparam logic [2:0] TY_START = 3'h0;
  localparam logic [2:0] restart_condition_type = 3'h1;
  localparam logic [2:0] TY_STOP = 3'h2;
  localparam logic [2:0] TY_NACK = 3'h3;
  localparam logic [2:0] TY_ADDR = 3'h4;
  localparam logic [2:0] TY_DATA = 3'h5;
  localparam logic [2:0] address_and_data_type = 3'h6;
  // direction qualifier
  localparam logic [1:0] ACC_EITHER = 2'h0;
  localparam logic [1:0] ACC_READ = 2'h1;
  localparam logic [1:0] ACC_WRITE = 2'h2;
  // compare operators
  localparam logic [2:0] OP_EQ = 3'h0;
  localparam logic [2:0] OP_NE = 3'h1;
  localparam logic [2:0] OP_LT = 3'h2;
  localparam logic [2:0] OP_LE = 3'h3;
  localparam logic [2:0] OP_GT = 3'h4;
  localparam logic [2:0] OP_GE = 3'h5;
  localparam logic [2:0] inside_range_operator = 3'h6;
  localparam logic [2:0] outside_range_operator = 3'h7;
  // relation codes
  localparam logic [1:0] REL_EQ = 2'h0;
  localparam logic [1:0] REL_LT = 2'h1;
  localparam logic [1:0] REL_GT = 2'h2;
  // status bits
  localparam int unsigned EV_TRIG = 0;
  localparam int unsigned EV_START = 1;
  localparam int unsigned EV_STOP = 2;
  localparam int unsigned EV_NACK = 3;
  localparam int unsigned EV_W = 4;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
  localparam logic [3:0] ACK_BIT = 4'h8;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ADDR1 = 4'b0010,
    ST_ADDR2 = 4'b0100,
    ST_DATA = 4'b1000
  } i2ctg_state_e;
endpackage : i2ctg_pkg

// >>> core/i2ctg_top.sv
/*
 i2ctg_top: passive i2c monitor raising a trigger on a selected condition.
 assumes scl/sda arrive asynchronously from the observed bus, and a
 register master on clk that never needs wait states.
*/
// What this block does
// (R01) seven trigger types, start after reset
// (R02) repeated start fires only inside open transfer
// (R03) stop mode fires on stop, ends frame
// (R04) combined fires on address and data match
// (R05) address qualified by read/write/either, either default
// (R06) eight address operators, equal after reset
// (R07) first address value, second upper range bound
// (R08) address not acknowledged fires, on after reset
// (R09) 7 or 10 bit address, 7 default
// (R10) six data operators, equal after reset
// (R11) pattern msb first, 64 bits, bytewise compare
// (R12) skip 1..4096 data bytes, 1 default
// (R13) read-end nack fires when enabled, default on
// (R14) write data nack fires when enabled, default on
// (R15) ack sampled ninth clock high, high is nack
`timescale 1ns/1ps
`default_nettype none
module i2ctg_top (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  // observed bus
  input wire logic scl_in,
  input wire logic sda_in,
  // trigger outputs
  output logic trig_pulse,
  output logic irq
);
  function automatic logic [1:0] rel_of(input logic [9:0] a, input logic [9:0] b);
    rel_of = (a == b) ? i2ctg_pkg::REL_EQ : ((a < b) ? i2ctg_pkg::REL_LT : i2ctg_pkg::REL_GT);
  endfunction : rel_of

  // rel_hi only matters for the two range operators
  function automatic logic op_ok(input logic [2:0] op, input logic [1:0] r, input logic [1:0] rh);
    case (op)
      i2ctg_pkg::OP_EQ: op_ok = (r == i2ctg_pkg::REL_EQ);
      i2ctg_pkg::OP_NE: op_ok = (r != i2ctg_pkg::REL_EQ);
      i2ctg_pkg::OP_LT: op_ok = (r == i2ctg_pkg::REL_LT);
      i2ctg_pkg::OP_LE: op_ok = (r != i2ctg_pkg::REL_GT);
      i2ctg_pkg::OP_GT: op_ok = (r == i2ctg_pkg::REL_GT);
      i2ctg_pkg::OP_GE: op_ok = (r != i2ctg_pkg::REL_LT);
      i2ctg_pkg::inside_range_operator:
        op_ok = (r != i2ctg_pkg::REL_LT) && (rh != i2ctg_pkg::REL_GT);
      i2ctg_pkg::outside_range_operator:
        op_ok = (r == i2ctg_pkg::REL_LT) || (rh == i2ctg_pkg::REL_GT);
      default: op_ok = 1'b0;
    endcase
  endfunction : op_ok

  // registers
  logic [14:0] ctrl_q;
  logic [9:0] addr_lo_q;
  logic [9:0] address_upper_bound;
  logic [63:0] data_pattern_lower;
  logic [3:0] pat_len_q;
  logic [12:0] data_byte_offset;
  logic [3:0] status_q;
  logic [3:0] mask_q;
  logic [31:0] reg_rdata_q;
  // line conditioning
  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;
  logic scl_f, sda_f, scl_p, sda_p;
  // protocol tracking
  i2ctg_pkg::i2ctg_state_e st_q, st_d;
  logic [3:0] bitcnt_q;
  logic [7:0] shreg_q;
  logic [1:0] hi_q;
  logic [7:0] lo_saved_q;
  logic rw_q, open_q, addr_hit_q;
  logic [12:0] dcnt_q;
  logic [1:0] rel_q;
  logic trig_q;

  // control fields
  wire [2:0] trig_type = ctrl_q[i2ctg_pkg::CTL_TYPE +: 3];
  wire [1:0] access_sel = ctrl_q[i2ctg_pkg::CTL_ACC +: 2];
  wire [2:0] address_compare_operator = ctrl_q[i2ctg_pkg::CTL_AOP +: 3];
  wire address_noack_detect = ctrl_q[i2ctg_pkg::CTL_ADDRESS_NOACK_DETECT];
  wire address_length_select = ctrl_q[i2ctg_pkg::CTL_ALEN];
  wire [2:0] data_compare_operator = ctrl_q[i2ctg_pkg::CTL_DOP +: 3];
  wire read_end_noack_detect = ctrl_q[i2ctg_pkg::CTL_READ_END_NOACK_DETECT];
  wire write_data_noack_detect = ctrl_q[i2ctg_pkg::CTL_WRITE_DATA_NOACK_DETECT];

  // register decode
  wire we_ctrl = reg_we && (reg_addr == i2ctg_pkg::OFF_CTRL);
  wire we_alo = reg_we && (reg_addr == i2ctg_pkg::OFF_ADDR_LO);
  wire we_ahi = reg_we && (reg_addr == i2ctg_pkg::OFF_ADDR_HI);
  wire we_plo = reg_we && (reg_addr == i2ctg_pkg::OFF_PAT_LO);
  wire we_phi = reg_we && (reg_addr == i2ctg_pkg::OFF_PAT_HI);
  wire we_plen = reg_we && (reg_addr == i2ctg_pkg::OFF_PAT_LEN);
  wire we_off = reg_we && (reg_addr == i2ctg_pkg::OFF_OFFSET);
  wire we_stat = reg_we && (reg_addr == i2ctg_pkg::OFF_STATUS);
  wire we_mask = reg_we && (reg_addr == i2ctg_pkg::OFF_MASK);

  // bus edges; sampling at scl rise is the start of the high phase
  wire scl_rise = scl_f && !scl_p;
  wire start_ev = scl_f && scl_p && sda_p && !sda_f;
  wire stop_ev = scl_f && scl_p && !sda_p && sda_f;
  // clock edges between frames carry no bits
  wire framed = (st_q != i2ctg_pkg::ST_IDLE);
  wire bit_ev = scl_rise && framed;
  wire ack_ev = bit_ev && (bitcnt_q == i2ctg_pkg::ACK_BIT); // see (R15)
  wire nack = sda_f; // see (R15)
  wire in_a1 = (st_q == i2ctg_pkg::ST_ADDR1);
  wire in_a2 = (st_q == i2ctg_pkg::ST_ADDR2);
  wire in_data = (st_q == i2ctg_pkg::ST_DATA);

  // address assembly
  wire pfx = address_length_select && (shreg_q[7:3] == i2ctg_pkg::TEN_BIT_PREFIX); // see (R09)
  wire go_a2 = in_a1 && pfx && !shreg_q[0];
  wire addr_done = ack_ev && ((in_a1 && !go_a2) || in_a2);
  wire [9:0] addr_val = in_a2 ? {hi_q, shreg_q} :
                        (pfx ? {shreg_q[2:1], lo_saved_q} : {3'h0, shreg_q[7:1]}); // see (R09)
  wire rw_cur = in_a1 ? shreg_q[0] : rw_q;
  wire dir_ok = (access_sel == i2ctg_pkg::ACC_EITHER) ||
                ((access_sel == i2ctg_pkg::ACC_READ) && rw_cur) ||
                ((access_sel == i2ctg_pkg::ACC_WRITE) && !rw_cur); // see (R05)
  wire [1:0] rel_lo = rel_of(addr_val, addr_lo_q); // see (R07)
  wire [1:0] rel_hi = rel_of(addr_val, address_upper_bound); // see (R07)
  wire addr_ok = dir_ok && op_ok(address_compare_operator, rel_lo, rel_hi); // see (R06)

  // missing acknowledge cases
  wire nack_addr = ack_ev && (in_a1 || in_a2) && nack && address_noack_detect; // see (R08)
  wire nack_rd = ack_ev && in_data && rw_q && nack && read_end_noack_detect; // see (R13)
  wire nack_wr = ack_ev && in_data && !rw_q && nack && write_data_noack_detect; // see (R14)
  wire any_nack = ack_ev && nack;

  // data window and bytewise pattern compare
  wire [12:0] dk = dcnt_q - data_byte_offset;
  wire in_win = (dcnt_q >= data_byte_offset) && (dk < {9'h000, pat_len_q}); // see (R12)
  wire [2:0] pidx = 3'(pat_len_q - 4'h1 - {1'b0, dk[2:0]});
  wire [63:0] pshift = data_pattern_lower >> {pidx, 3'h0}; // see (R11)
  wire [7:0] pbyte = pshift[7:0];
  wire [1:0] rel_byte = rel_of({2'h0, shreg_q}, {2'h0, pbyte});
  // earlier bytes decide first, so the pattern orders like a big number
  wire [1:0] rel_n = ((dk[2:0] == 3'h0) || (rel_q == i2ctg_pkg::REL_EQ)) ? rel_byte : rel_q;
  wire last_byte = (dk[3:0] == (pat_len_q - 4'h1));
  wire data_hit = ack_ev && in_data && in_win && last_byte &&
                  op_ok(data_compare_operator, rel_n, rel_n); // see (R10)

  // trigger selection
  logic fire;
  always_comb begin
    case (trig_type) // see (R01)
      i2ctg_pkg::TY_START: fire = start_ev;
      i2ctg_pkg::restart_condition_type: fire = start_ev && open_q; // see (R02)
      i2ctg_pkg::TY_STOP: fire = stop_ev; // see (R03)
      // one type covers all three enabled nack cases
      i2ctg_pkg::TY_NACK: fire = nack_addr || nack_rd || nack_wr;
      i2ctg_pkg::TY_ADDR: fire = addr_done && addr_ok;
      i2ctg_pkg::TY_DATA: fire = data_hit;
      i2ctg_pkg::address_and_data_type: fire = data_hit && addr_hit_q; // see (R04)
      default: fire = 1'b0;
    endcase
  end

  // protocol state
  always_comb begin
    st_d = st_q;
    if (start_ev) begin
      st_d = i2ctg_pkg::ST_ADDR1;
    end else if (stop_ev) begin
      st_d = i2ctg_pkg::ST_IDLE; // see (R03)
    end else if (ack_ev) begin
      case (st_q)
        i2ctg_pkg::ST_ADDR1: st_d = nack ? i2ctg_pkg::ST_IDLE :
                                    (go_a2 ? i2ctg_pkg::ST_ADDR2 : i2ctg_pkg::ST_DATA);
        i2ctg_pkg::ST_ADDR2: st_d = nack ? i2ctg_pkg::ST_IDLE : i2ctg_pkg::ST_DATA;
        i2ctg_pkg::ST_DATA: st_d = i2ctg_pkg::ST_DATA;
        default: st_d = i2ctg_pkg::ST_IDLE;
      endcase
    end
  end

  wire [3:0] ev_now = {any_nack, stop_ev, start_ev, fire};
  // a new event beats a simultaneous clear
  wire [3:0] status_d = (status_q & ~(we_stat ? reg_wdata[3:0] : 4'h0)) | ev_now;
  // debug view; the address field is live, not latched
  wire [31:0] state_word = {12'h000, addr_val, rel_q, addr_hit_q, rw_q, st_q, open_q, 1'b0};
  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr)
      i2ctg_pkg::OFF_CTRL: rd_mux = {17'h00000, ctrl_q};
      i2ctg_pkg::OFF_ADDR_LO: rd_mux = {22'h000000, addr_lo_q};
      i2ctg_pkg::OFF_ADDR_HI: rd_mux = {22'h000000, address_upper_bound};
      i2ctg_pkg::OFF_PAT_LO: rd_mux = data_pattern_lower[31:0];
      i2ctg_pkg::OFF_PAT_HI: rd_mux = data_pattern_lower[63:32];
      i2ctg_pkg::OFF_PAT_LEN: rd_mux = {28'h0000000, pat_len_q};
      i2ctg_pkg::OFF_OFFSET: rd_mux = {19'h00000, data_byte_offset};
      i2ctg_pkg::OFF_STATUS: rd_mux = {28'h0000000, status_q};
      i2ctg_pkg::OFF_MASK: rd_mux = {28'h0000000, mask_q};
      i2ctg_pkg::OFF_STATE: rd_mux = state_word;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // register file
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_q <= i2ctg_pkg::CTRL_RST; // see (R01)
      addr_lo_q <= 10'h000;
      address_upper_bound <= 10'h000;
      data_pattern_lower <= 64'h0000000000000000;
      pat_len_q <= i2ctg_pkg::PAT_LEN_RST;
      data_byte_offset <= i2ctg_pkg::OFFSET_RST; // see (R12)
      status_q <= 4'h0;
      mask_q <= 4'h0;
      reg_rdata_q <= 32'h00000000;
    end else begin
      if (we_ctrl) ctrl_q <= reg_wdata[14:0];
      if (we_alo) addr_lo_q <= reg_wdata[9:0];
      if (we_ahi) address_upper_bound <= reg_wdata[9:0];
      if (we_plo) data_pattern_lower[31:0] <= reg_wdata;
      if (we_phi) data_pattern_lower[63:32] <= reg_wdata;
      // lengths outside 1..8 bytes are clamped
      if (we_plen) pat_len_q <= (reg_wdata[3:0] == 4'h0) ? 4'h1 :
                                (reg_wdata[3] ? 4'h8 : reg_wdata[3:0]); // see (R11)
      if (we_off) data_byte_offset <= (reg_wdata[12:0] == 13'h0000) ? 13'h0001 :
                                      ((reg_wdata[12:0] > 13'h1000) ? 13'h1000 : reg_wdata[12:0]);
      if (we_mask) mask_q <= reg_wdata[3:0];
      status_q <= status_d;
      reg_rdata_q <= reg_re ? rd_mux : 32'h00000000;
    end
  end

  // line synchroniser and agreement filter
  // a glitch shorter than one clock never reaches the filtered lines
  always_ff @(posedge clk) begin
    if (!resetn) begin
      {scl_s1, scl_s2, scl_s3} <= 3'h7;
      {sda_s1, sda_s2, sda_s3} <= 3'h7;
      {scl_f, sda_f, scl_p, sda_p} <= 4'hF;
    end else begin
      {scl_s1, scl_s2, scl_s3} <= {scl_in, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_s3} <= {sda_in, sda_s1, sda_s2};
      if (scl_s2 == scl_s3) scl_f <= scl_s3;
      if (sda_s2 == sda_s3) sda_f <= sda_s3;
      scl_p <= scl_f;
      sda_p <= sda_f;
    end
  end

  // bit, byte and transfer tracking
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= i2ctg_pkg::ST_IDLE;
      bitcnt_q <= 4'h0;
      shreg_q <= 8'h00;
      hi_q <= 2'h0;
      lo_saved_q <= 8'h00;
      rw_q <= 1'b0;
      open_q <= 1'b0;
      addr_hit_q <= 1'b0;
      dcnt_q <= 13'h0000;
      rel_q <= i2ctg_pkg::REL_EQ;
      trig_q <= 1'b0;
    end else begin
      st_q <= st_d;
      trig_q <= fire;
      if (start_ev) begin
        open_q <= 1'b1; // see (R02)
        addr_hit_q <= 1'b0;
        bitcnt_q <= 4'h0;
      end else if (stop_ev) begin
        open_q <= 1'b0; // see (R03)
      end else if (bit_ev) begin
        bitcnt_q <= ack_ev ? 4'h0 : bitcnt_q + 4'h1;
        if (!ack_ev) shreg_q <= {shreg_q[6:0], sda_f};
      end
      if (ack_ev && in_a1) begin
        hi_q <= shreg_q[2:1];
        rw_q <= shreg_q[0];
      end
      if (ack_ev && in_a2) lo_saved_q <= shreg_q;
      if (addr_done) begin
        addr_hit_q <= addr_ok; // see (R04)
        dcnt_q <= 13'h0000;
      // saturate so a very long transfer never wraps back into the window
      end else if (ack_ev && in_data && (dcnt_q != 13'h1FFF)) begin
        dcnt_q <= dcnt_q + 13'h0001;
      end
      if (ack_ev && in_data && in_win) rel_q <= rel_n; // see (R11)
    end
  end

  assign reg_rdata = reg_rdata_q;
  assign trig_pulse = trig_q;
  assign irq = |(status_q & mask_q);
endmodule : i2ctg_top
`default_nettype wire

// >>> test/i2ctg_bus_model.sv
/*
 i2ctg_bus_model: controller and targets on the observed bus, as tasks.
 assumes open-drain lines with pull-ups; only one line moves per step.
*/
`timescale 1ns/1ps
`default_nettype none
module i2ctg_bus_model (
  // clock
  input wire logic clk,
  // bus lines
  output var logic scl,
  output var logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // ten clocks per step keeps well clear of the input filter
  task automatic step(input logic c, input logic d);
    repeat (10) @(posedge clk);
    scl <= c;
    sda <= d;
  endtask : step
  task automatic put_start();
    step(scl, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask : put_start
  task automatic put_stop();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask : put_stop
  task automatic put_bit(input logic d);
    step(1'b0, d);
    step(1'b1, d);
    step(1'b0, d);
  endtask : put_bit
  task automatic put_byte(input logic [7:0] b, input logic nak);
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
    put_bit(nak);
  endtask : put_byte
endmodule : i2ctg_bus_model
`default_nettype wire

// >>> test/i2ctg_monitor.sv
/*
 i2ctg_monitor: port assertions for the i2c protocol trigger.
 assumes bus half-bit phases of ten clocks or more, bound to i2ctg_top.
*/
`timescale 1ns/1ps
`default_nettype none
module i2ctg_chk (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [31:0] reg_rdata,
  // observed bus
  input wire logic scl_in,
  input wire logic sda_in,
  // trigger outputs
  input wire logic trig_pulse,
  input wire logic irq
);
  logic [3:0] idle_q;
  logic [3:0] idle_d;
  logic wr_seen_q;
  // saturating count of cycles with both lines high
  assign idle_d = !(scl_in && sda_in) ? 4'h0 : (idle_q == 4'hF) ? idle_q : idle_q + 4'h1;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      idle_q <= 4'hF;
      wr_seen_q <= 1'b0;
    end else begin
      idle_q <= idle_d;
      wr_seen_q <= wr_seen_q | reg_we;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_CTRL_DEFAULT: assert property (
    reg_re && !wr_seen_q && reg_addr == i2ctg_pkg::OFF_CTRL
    |=> reg_rdata == {17'h0, i2ctg_pkg::CTRL_RST}) else $error("control default wrong");
  AST_OFFSET_DEFAULT: assert property (
    reg_re && !wr_seen_q && reg_addr == i2ctg_pkg::OFF_OFFSET
    |=> reg_rdata == 32'h00000001) else $error("offset default wrong");
  AST_TRIG_ONE: assert property (trig_pulse |=> !trig_pulse [*3])
    else $error("trigger pulse too long");
  AST_TRIG_NEAR_EDGE: assert property (trig_pulse |-> idle_q < 4'hA)
    else $error("trigger with idle bus");
  AST_TRIG_SCL_HIGH: assert property (trig_pulse |-> $past(scl_in, 2))
    else $error("trigger outside clock high phase");
  AST_RDATA_IDLE: assert property (!$past(reg_re) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  AST_UNMAPPED: assert property (reg_re && reg_addr == 8'hFC |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  AST_IRQ_HOLD: assert property (irq && !reg_we |=> irq)
    else $error("interrupt dropped without write");
endmodule : i2ctg_chk
bind i2ctg_top i2ctg_chk u_chk (.clk, .resetn, .reg_addr, .reg_wdata, .reg_we, .reg_re,
  .reg_rdata, .scl_in, .sda_in, .trig_pulse, .irq);
`default_nettype wire

// >>> test/testbench.sv
/*
 testbench: drives registers and bus frames, counts trigger pulses.
 assumes the monitor is bound to i2ctg_top and the bus model task set.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk;
  logic resetn;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_we;
  logic reg_re;
  logic [31:0] reg_rdata;
  logic scl_w;
  logic sda_w;
  logic trig_pulse;
  logic irq;
  int bad_count;
  int num_checks;
  int trig_cnt;
  i2ctg_top u_dut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
    .scl_in(scl_w), .sda_in(sda_w), .trig_pulse, .irq);
  i2ctg_bus_model u_bus (.clk, .scl(scl_w), .sda(sda_w));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (trig_pulse === 1'b1) trig_cnt <= trig_cnt + 1;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      bad_count++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    chk("read data", e, reg_rdata);
  endtask : rd
  // one frame: address, filler byte, last byte, optional restart, stop
  task automatic run(input logic [14:0] ctl, input logic [9:0] alo, input logic [9:0] ahi,
    input logic [7:0] ab, input logic ak, input logic [7:0] db, input logic dk,
    input logic rs, input int n);
    int base;
    wr(i2ctg_pkg::OFF_CTRL, {17'h0, ctl});
    wr(i2ctg_pkg::OFF_ADDR_LO, {22'h0, alo});
    wr(i2ctg_pkg::OFF_ADDR_HI, {22'h0, ahi});
    base = trig_cnt;
    u_bus.put_start();
    u_bus.put_byte(ab, ak);
    u_bus.put_byte(8'h11, 1'b0);
    u_bus.put_byte(db, dk);
    if (rs) u_bus.put_start();
    u_bus.put_stop();
    repeat (20) @(posedge clk);
    chk("trigger count", 32'(n), 32'(trig_cnt - base));
  endtask : run
  // data-type frame with data bytes 11 3C 5A, pattern in the low word
  task automatic run3(input logic [31:0] pat, input logic [31:0] len, input logic [31:0] off,
    input int n);
    int base;
    wr(i2ctg_pkg::OFF_CTRL, 32'h00006105);
    wr(i2ctg_pkg::OFF_PAT_HI, 32'h00000000);
    wr(i2ctg_pkg::OFF_PAT_LO, pat);
    wr(i2ctg_pkg::OFF_PAT_LEN, len);
    wr(i2ctg_pkg::OFF_OFFSET, off);
    base = trig_cnt;
    u_bus.put_start();
    u_bus.put_byte(8'hA0, 1'b0);
    u_bus.put_byte(8'h11, 1'b0);
    u_bus.put_byte(8'h3C, 1'b0);
    u_bus.put_byte(8'h5A, 1'b0);
    u_bus.put_stop();
    repeat (20) @(posedge clk);
    chk("pattern trigger count", 32'(n), 32'(trig_cnt - base));
  endtask : run3
  initial begin
    #3_000_000;
    bad_count++;
    finish_test();
  end
  initial begin
    logic [7:0] hits;
    resetn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    trig_cnt = 0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    rd(i2ctg_pkg::OFF_CTRL, {17'h0, i2ctg_pkg::CTRL_RST});
    rd(i2ctg_pkg::OFF_OFFSET, 32'h00000001);
    rd(i2ctg_pkg::OFF_STATUS, 32'h0);
    rd(i2ctg_pkg::OFF_STATE, 32'h00000004);
    wr(8'hFC, 32'hFFFFFFFF);
    rd(8'hFC, 32'h0);
    wr(i2ctg_pkg::OFF_PAT_LO, 32'h0000003C);
    run(15'h6100, 10'h0, 10'h0, 8'hA0, 1'b0, 8'h3C, 1'b0, 1'b1, 2);
    wr(i2ctg_pkg::OFF_MASK, 32'h00000001);
    #1 chk("irq raised", 32'h1, {31'h0, irq});
    wr(i2ctg_pkg::OFF_STATUS, 32'h00000001);
    #1 chk("irq cleared", 32'h0, {31'h0, irq});
    run(15'h6101, 10'h0, 10'h0, 8'hA0, 1'b0, 8'h3C, 1'b0, 1'b0, 0);
    run(15'h6101, 10'h0, 10'h0, 8'hA0, 1'b0, 8'h3C, 1'b0, 1'b1, 1);
    run(15'h6102, 10'h0, 10'h0, 8'hA0, 1'b0, 8'h3C, 1'b0, 1'b0, 1);
    for (int op = 0; op < 16; op++) begin
      hits = (op < 8) ? 8'h69 : 8'h8E;
      run(15'h6104 | 15'(op % 8) << 5, (op < 8) ? 10'h050 : 10'h051, 10'h060, 8'hA0, 1'b0,
        8'h3C, 1'b0, 1'b0, int'(hits[op % 8]));
    end
    run(15'h610C, 10'h050, 10'h0, 8'hA0, 1'b0, 8'h3C, 1'b0, 1'b0, 0);
    run(15'h6114, 10'h050, 10'h0, 8'hA0, 1'b0, 8'h3C, 1'b0, 1'b0, 1);
    run(15'h610C, 10'h050, 10'h0, 8'hA1, 1'b0, 8'h3C, 1'b1, 1'b0, 1);
    run(15'h6103, 10'h0, 10'h0, 8'hA0, 1'b1, 8'h3C, 1'b0, 1'b0, 1);
    run(15'h6003, 10'h0, 10'h0, 8'hA0, 1'b1, 8'h3C, 1'b0, 1'b0, 0);
    run(15'h4003, 10'h0, 10'h0, 8'hA0, 1'b0, 8'h3C, 1'b1, 1'b0, 1);
    run(15'h2003, 10'h0, 10'h0, 8'hA0, 1'b0, 8'h3C, 1'b1, 1'b0, 0);
    run(15'h2003, 10'h0, 10'h0, 8'hA1, 1'b0, 8'h3C, 1'b1, 1'b0, 1);
    run(15'h4003, 10'h0, 10'h0, 8'hA1, 1'b0, 8'h3C, 1'b1, 1'b0, 0);
    run(15'h6105, 10'h0, 10'h0, 8'hA0, 1'b0, 8'h3C, 1'b0, 1'b0, 1);
    run(15'h6105, 10'h0, 10'h0, 8'hA0, 1'b0, 8'h3D, 1'b0, 1'b0, 0);
    run(15'h7105, 10'h0, 10'h0, 8'hA0, 1'b0, 8'h3D, 1'b0, 1'b0, 1);
    run(15'h6905, 10'h0, 10'h0, 8'hA0, 1'b0, 8'h3D, 1'b0, 1'b0, 0);
    run(15'h6106, 10'h050, 10'h0, 8'hA0, 1'b0, 8'h3C, 1'b0, 1'b0, 1);
    run(15'h6106, 10'h050, 10'h0, 8'hA2, 1'b0, 8'h3C, 1'b0, 1'b0, 0);
    run(15'h6304, 10'h211, 10'h0, 8'hF4, 1'b0, 8'h3C, 1'b0, 1'b0, 1);
    run(15'h6104, 10'h211, 10'h0, 8'hF4, 1'b0, 8'h3C, 1'b0, 1'b0, 0);
    wr(i2ctg_pkg::OFF_PAT_LEN, 32'h00000000);
    rd(i2ctg_pkg::OFF_PAT_LEN, 32'h00000001);
    wr(i2ctg_pkg::OFF_PAT_LEN, 32'h0000000F);
    rd(i2ctg_pkg::OFF_PAT_LEN, 32'h00000008);
    wr(i2ctg_pkg::OFF_PAT_HI, 32'hA5C30F96);
    rd(i2ctg_pkg::OFF_PAT_HI, 32'hA5C30F96);
    wr(i2ctg_pkg::OFF_OFFSET, 32'h00001FFF);
    rd(i2ctg_pkg::OFF_OFFSET, 32'h00001000);
    run3(32'h00003C5A, 32'h2, 32'h1, 1);
    run3(32'h00005A3C, 32'h2, 32'h1, 0);
    run3(32'h0000005A, 32'h1, 32'h2, 1);
    run3(32'h0000005A, 32'h1, 32'h1, 0);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
